// ---- alf_cfg.svh ----
// Constants of the address look-up and forwarding engine.
`ifndef ALF_CFG_SVH
`define ALF_CFG_SVH
`define ALF_NUM_PORTS 5
`define ALF_ALL_PORTS 5'h1F
`define ALF_TBL_DEPTH 1024
`define ALF_TBL_LAST 10'h3FF
`define ALF_BUF_COUNT 10'h200
`define ALF_BUF_OFF_ZERO 7'h00
`define ALF_FIFO_DEPTH 8
`define ALF_FIFO_WIDTH 16
`define ALF_MIN_FRAME 11'h040
`define ALF_MAX_FRAME 11'h600
`define ALF_SA_START 11'h006
`define ALF_TYPE_START 11'h00C
`define ALF_OP_START 11'h00E
`define ALF_QUANTA_START 11'h010
`define ALF_HDR_END 11'h012
`define ALF_MCAST_BIT 40
`define ALF_PAUSE_DA 48'h0180C2000001
`define ALF_PAUSE_TYPE 16'h8808
`define ALF_PAUSE_OP 16'h0001
`define ALF_CLK_HZ 250000000
`define ALF_AGE_TIME_S 300
`define ALF_AGE_TOL_S 75
`endif

// ---- alf_pkg.sv ----
// Types of the address look-up and forwarding engine.
package alf_pkg;
    typedef enum logic [1:0] {ST_RECV, ST_SCAN, ST_UPDATE, ST_SEND} eng_state_t;
    typedef logic [47:0] mac_t;
    typedef logic [4:0] port_map_t;
    typedef logic [2:0] port_t;
    typedef logic [2:0] stamp_t;
endpackage : alf_pkg

// ---- stream_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ns
`include "alf_cfg.svh"
module stream_fifo #(
    parameter int WIDTH = `ALF_FIFO_WIDTH,
    parameter int DEPTH = `ALF_FIFO_DEPTH
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    // Depth must be a power of two; pointers wrap by overflow
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic not_full_r, not_full_nxt;
    logic push, pop;

    assign in_ready_o = not_full_r;
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = mem_r[rd_r];

    always_comb begin
        push = in_valid_i && not_full_r;
        pop = out_valid_o && out_ready_i;
        wr_nxt = push ? wr_r + AW'(1) : wr_r;
        rd_nxt = pop ? rd_r + AW'(1) : rd_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        not_full_nxt = (cnt_nxt != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
            not_full_r <= 1'b0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
            not_full_r <= not_full_nxt;
        end
    end

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_r[wr_r] <= in_data_i;
        end
    end
endmodule : stream_fifo

// ---- address_lookup_forwarding.sv ----
// Layer-2 address learning, aging, forwarding decision and store-and-forward buffering.
`timescale 1ns/1ns
`include "alf_cfg.svh"
module address_lookup_forwarding #(
    parameter longint unsigned AGE_TICK_CYCLES = 64'(`ALF_AGE_TOL_S) * 64'(`ALF_CLK_HZ)
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic rx_valid_i,
    input wire logic rx_sof_i,
    input wire logic rx_eof_i,
    input wire logic [7:0] rx_data_i,
    input wire logic [2:0] rx_port_i,
    input wire logic [2:0] rx_error_i,
    output logic rx_ready_o,
    input wire logic aging_enable_i,
    output logic lookup_busy_o,
    output logic [47:0] destination_mac_o,
    output logic [2:0] ingress_port_o,
    input wire logic static_hit_i,
    input wire logic [4:0] static_map_i,
    input wire logic [4:0] vlan_member_map_i,
    input wire logic [4:0] stp_forward_map_i,
    input wire logic igmp_valid_i,
    input wire logic [4:0] igmp_map_i,
    input wire logic [4:0] mirror_map_i,
    input wire logic auth_ok_i,
    input wire logic acl_valid_i,
    input wire logic [4:0] acl_map_i,
    output logic pause_valid_o,
    output logic [2:0] pause_port_o,
    output logic [15:0] pause_quanta_o,
    output logic tx_valid_o,
    output logic tx_sof_o,
    output logic tx_eof_o,
    output logic [7:0] tx_data_o,
    output logic [4:0] tx_port_map_o,
    input wire logic tx_ready_i,
    output logic drop_o,
    output logic [9:0] buffers_free_o
);
    localparam alf_pkg::stamp_t EXPIRE_TICKS = 3'(`ALF_AGE_TIME_S / `ALF_AGE_TOL_S);

    function automatic logic [15:0] pool_addr(input logic [8:0] start, input logic [10:0] off);
        pool_addr = {start + 9'(off[10:7]), off[6:0]};
    endfunction : pool_addr

    // Ingress FIFO word: port, errors, sof, eof, data
    logic fifo_valid, fifo_pop;
    logic [15:0] fifo_word;
    stream_fifo #(.WIDTH(`ALF_FIFO_WIDTH), .DEPTH(`ALF_FIFO_DEPTH)) u_fifo (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(rx_valid_i),
        .in_data_i({rx_port_i, rx_error_i, rx_sof_i, rx_eof_i, rx_data_i}),
        .in_ready_o(rx_ready_o),
        .out_valid_o(fifo_valid),
        .out_data_o(fifo_word),
        .out_ready_i(fifo_pop)
    );

    // Storage is flip-flops: pool and address table
    logic [7:0] pool_r [65536];
    logic tbl_valid_r [`ALF_TBL_DEPTH];
    alf_pkg::mac_t tbl_mac_r [`ALF_TBL_DEPTH];
    alf_pkg::port_t tbl_port_r [`ALF_TBL_DEPTH];
    alf_pkg::stamp_t tbl_stamp_r [`ALF_TBL_DEPTH];

    alf_pkg::eng_state_t state_r, state_nxt;
    logic [10:0] len_r, len_nxt, rd_len_r, rd_len_nxt;
    alf_pkg::mac_t da_r, da_nxt, sa_r, sa_nxt, dest_r, dest_nxt;
    logic [15:0] type_r, type_nxt, op_r, op_nxt, quanta_r, quanta_nxt;
    alf_pkg::port_t in_port_r, in_port_nxt, da_port_r, da_port_nxt;
    logic [2:0] err_r, err_nxt;
    logic [8:0] start_buf_r, start_buf_nxt;
    logic [9:0] buf_free_r, buf_free_nxt, alloc_r, alloc_nxt;
    logic [9:0] scan_idx_r, scan_idx_nxt, sa_idx_r, sa_idx_nxt, free_idx_r, free_idx_nxt;
    logic sa_hit_r, sa_hit_nxt, da_hit_r, da_hit_nxt, free_hit_r, free_hit_nxt;
    logic busy_r, busy_nxt, drop_r, drop_nxt;
    logic pause_valid_r, pause_valid_nxt;
    alf_pkg::port_t pause_port_r, pause_port_nxt;
    logic [15:0] pause_quanta_r, pause_quanta_nxt;
    logic tx_valid_r, tx_valid_nxt, tx_sof_r, tx_sof_nxt, tx_eof_r, tx_eof_nxt;
    logic [7:0] tx_data_r, tx_data_nxt;
    alf_pkg::port_map_t tx_map_r, tx_map_nxt;

    // Shared write ports
    logic pool_we;
    logic [15:0] pool_wa, pool_ra;
    logic tbl_we, tbl_wvalid;
    logic [9:0] tbl_widx;
    alf_pkg::stamp_t epoch_r, epoch_nxt;

    // Working terms
    logic [10:0] b_idx;
    logic [9:0] free_base;
    logic good, is_pause, is_mcast, local_hit, forward;
    alf_pkg::port_map_t in_onehot, initial_port_map, final_port_map;

    // Aging group
    logic [63:0] tick_r, tick_nxt;
    logic [9:0] age_idx_r, age_idx_nxt;
    logic age_kill;

    always_comb begin
        state_nxt = state_r;
        len_nxt = len_r;
        rd_len_nxt = rd_len_r;
        da_nxt = da_r;
        sa_nxt = sa_r;
        dest_nxt = dest_r;
        type_nxt = type_r;
        op_nxt = op_r;
        quanta_nxt = quanta_r;
        in_port_nxt = in_port_r;
        da_port_nxt = da_port_r;
        err_nxt = err_r;
        start_buf_nxt = start_buf_r;
        buf_free_nxt = buf_free_r;
        alloc_nxt = alloc_r;
        scan_idx_nxt = scan_idx_r;
        sa_idx_nxt = sa_idx_r;
        free_idx_nxt = free_idx_r;
        sa_hit_nxt = sa_hit_r;
        da_hit_nxt = da_hit_r;
        free_hit_nxt = free_hit_r;
        busy_nxt = busy_r;
        drop_nxt = 1'b0;
        pause_valid_nxt = 1'b0;
        pause_port_nxt = pause_port_r;
        pause_quanta_nxt = pause_quanta_r;
        tx_valid_nxt = tx_valid_r;
        tx_sof_nxt = tx_sof_r;
        tx_eof_nxt = tx_eof_r;
        tx_data_nxt = tx_data_r;
        tx_map_nxt = tx_map_r;
        pool_we = 1'b0;
        pool_wa = '0;
        pool_ra = pool_addr(start_buf_r, rd_len_r);
        tbl_we = 1'b0;
        tbl_wvalid = 1'b0;
        tbl_widx = '0;
        fifo_pop = 1'b0;
        b_idx = '0;
        free_base = buf_free_r;
        good = (err_r == 3'h0) && (len_r >= `ALF_MIN_FRAME) && (len_r <= `ALF_MAX_FRAME);
        is_pause = (da_r == `ALF_PAUSE_DA) && (type_r == `ALF_PAUSE_TYPE) && (op_r == `ALF_PAUSE_OP);
        is_mcast = da_r[`ALF_MCAST_BIT];
        in_onehot = 5'h01 << in_port_r;
        local_hit = !is_mcast && !static_hit_i && da_hit_r && (da_port_r == in_port_r);
        // Stage one: multicast and unknown destinations flood
        if (is_mcast) begin
            initial_port_map = `ALF_ALL_PORTS;
        end else if (static_hit_i) begin
            initial_port_map = static_map_i;
        end else if (da_hit_r) begin
            initial_port_map = 5'h01 << da_port_r;
        end else begin
            initial_port_map = `ALF_ALL_PORTS;
        end
        initial_port_map = initial_port_map & ~in_onehot;
        // Stage two
        final_port_map = initial_port_map & vlan_member_map_i & stp_forward_map_i;
        if (igmp_valid_i && is_mcast) begin
            final_port_map = final_port_map & igmp_map_i;
        end
        final_port_map = (final_port_map | mirror_map_i) & ~in_onehot;
        if (!auth_ok_i) begin
            final_port_map = '0;
        end
        if (acl_valid_i) begin
            final_port_map = acl_map_i;
        end
        forward = good && !is_pause && !local_hit && (final_port_map != '0);
        unique case (state_r)
            alf_pkg::ST_RECV: begin
                fifo_pop = fifo_valid;
                if (fifo_valid) begin
                    b_idx = fifo_word[9] ? 11'h000 : len_r;
                    if (fifo_word[9]) begin
                        in_port_nxt = fifo_word[15:13];
                        free_base = buf_free_r + alloc_r;
                        alloc_nxt = '0;
                    end
                    // Oversize bytes are not stored; the frame is dropped at the end
                    if (b_idx < `ALF_MAX_FRAME) begin
                        pool_we = 1'b1;
                        pool_wa = pool_addr(start_buf_r, b_idx);
                        len_nxt = b_idx + 11'h001;
                        if (b_idx[6:0] == `ALF_BUF_OFF_ZERO) begin
                            buf_free_nxt = free_base - 10'h001;
                            alloc_nxt = (fifo_word[9] ? 10'h000 : alloc_r) + 10'h001;
                        end else begin
                            buf_free_nxt = free_base;
                        end
                    end else begin
                        len_nxt = `ALF_MAX_FRAME + 11'h001;
                        buf_free_nxt = free_base;
                    end
                    if (b_idx < `ALF_SA_START) begin
                        da_nxt = {da_r[39:0], fifo_word[7:0]};
                    end else if (b_idx < `ALF_TYPE_START) begin
                        sa_nxt = {sa_r[39:0], fifo_word[7:0]};
                    end else if (b_idx < `ALF_OP_START) begin
                        type_nxt = {type_r[7:0], fifo_word[7:0]};
                    end else if (b_idx < `ALF_QUANTA_START) begin
                        op_nxt = {op_r[7:0], fifo_word[7:0]};
                    end else if (b_idx < `ALF_HDR_END) begin
                        quanta_nxt = {quanta_r[7:0], fifo_word[7:0]};
                    end
                    if (fifo_word[8]) begin
                        err_nxt = fifo_word[12:10];
                        state_nxt = alf_pkg::ST_SCAN;
                        scan_idx_nxt = '0;
                        sa_hit_nxt = 1'b0;
                        da_hit_nxt = 1'b0;
                        free_hit_nxt = 1'b0;
                        busy_nxt = 1'b1;
                    end
                end
            end
            alf_pkg::ST_SCAN: begin
                // Full linear search: every slot usable, no hash collisions
                dest_nxt = da_r;
                if (tbl_valid_r[scan_idx_r] && (tbl_mac_r[scan_idx_r] == sa_r)) begin
                    sa_hit_nxt = 1'b1;
                    sa_idx_nxt = scan_idx_r;
                end
                if (tbl_valid_r[scan_idx_r] && (tbl_mac_r[scan_idx_r] == da_r)) begin
                    da_hit_nxt = 1'b1;
                    da_port_nxt = tbl_port_r[scan_idx_r];
                end
                if (!tbl_valid_r[scan_idx_r] && !free_hit_r) begin
                    free_hit_nxt = 1'b1;
                    free_idx_nxt = scan_idx_r;
                end
                scan_idx_nxt = scan_idx_r + 10'h001;
                if (scan_idx_r == `ALF_TBL_LAST) begin
                    state_nxt = alf_pkg::ST_UPDATE;
                end
            end
            alf_pkg::ST_UPDATE: begin
                busy_nxt = 1'b0;
                if (good) begin
                    tbl_we = 1'b1;
                    tbl_wvalid = 1'b1;
                    if (sa_hit_r) begin
                        tbl_widx = sa_idx_r;
                    end else if (free_hit_r) begin
                        tbl_widx = free_idx_r;
                    end else begin
                        tbl_widx = `ALF_TBL_LAST;
                    end
                end
                if (good && is_pause) begin
                    pause_valid_nxt = 1'b1;
                    pause_port_nxt = in_port_r;
                    pause_quanta_nxt = quanta_r;
                end
                if (forward) begin
                    state_nxt = alf_pkg::ST_SEND;
                    tx_map_nxt = final_port_map;
                    rd_len_nxt = '0;
                end else begin
                    drop_nxt = 1'b1;
                    state_nxt = alf_pkg::ST_RECV;
                    buf_free_nxt = buf_free_r + alloc_r;
                    start_buf_nxt = start_buf_r + alloc_r[8:0];
                    alloc_nxt = '0;
                    len_nxt = '0;
                end
            end
            alf_pkg::ST_SEND: begin
                if (!tx_valid_r || tx_ready_i) begin
                    if (rd_len_r < len_r) begin
                        tx_valid_nxt = 1'b1;
                        tx_data_nxt = pool_r[pool_ra];
                        tx_sof_nxt = (rd_len_r == 11'h000);
                        tx_eof_nxt = (rd_len_r == len_r - 11'h001);
                        rd_len_nxt = rd_len_r + 11'h001;
                    end else begin
                        tx_valid_nxt = 1'b0;
                        tx_sof_nxt = 1'b0;
                        tx_eof_nxt = 1'b0;
                        state_nxt = alf_pkg::ST_RECV;
                        buf_free_nxt = buf_free_r + alloc_r;
                        start_buf_nxt = start_buf_r + alloc_r[8:0];
                        alloc_nxt = '0;
                        len_nxt = '0;
                    end
                end
            end
        endcase
        // Aging shares the table write port only outside lookups
        if (age_kill) begin
            tbl_we = 1'b1;
            tbl_wvalid = 1'b0;
            tbl_widx = age_idx_r;
        end
    end

    always_comb begin
        tick_nxt = tick_r + 64'h1;
        epoch_nxt = epoch_r;
        if (tick_r >= AGE_TICK_CYCLES - 64'h1) begin
            tick_nxt = '0;
            epoch_nxt = epoch_r + 3'h1;
        end
        age_idx_nxt = age_idx_r + 10'h001;
        // Removed 3 to 4 ticks of 75 s after the last refresh, at the next age_idx_r visit outside ST_SCAN and ST_UPDATE
        age_kill = aging_enable_i && (state_r != alf_pkg::ST_SCAN) && (state_r != alf_pkg::ST_UPDATE) &&
                   tbl_valid_r[age_idx_r] && ((epoch_r - tbl_stamp_r[age_idx_r]) >= EXPIRE_TICKS);
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= alf_pkg::ST_RECV;
            len_r <= '0;
            rd_len_r <= '0;
            da_r <= '0;
            sa_r <= '0;
            dest_r <= '0;
            type_r <= '0;
            op_r <= '0;
            quanta_r <= '0;
            in_port_r <= '0;
            da_port_r <= '0;
            err_r <= '0;
            start_buf_r <= '0;
            buf_free_r <= `ALF_BUF_COUNT;
            alloc_r <= '0;
            scan_idx_r <= '0;
            sa_idx_r <= '0;
            free_idx_r <= '0;
            sa_hit_r <= 1'b0;
            da_hit_r <= 1'b0;
            free_hit_r <= 1'b0;
            busy_r <= 1'b0;
            drop_r <= 1'b0;
            pause_valid_r <= 1'b0;
            pause_port_r <= '0;
            pause_quanta_r <= '0;
            tx_valid_r <= 1'b0;
            tx_sof_r <= 1'b0;
            tx_eof_r <= 1'b0;
            tx_data_r <= '0;
            tx_map_r <= '0;
            tick_r <= '0;
            epoch_r <= '0;
            age_idx_r <= '0;
            for (int i = 0; i < `ALF_TBL_DEPTH; i++) begin
                tbl_valid_r[i] <= 1'b0;
            end
        end else begin
            state_r <= state_nxt;
            len_r <= len_nxt;
            rd_len_r <= rd_len_nxt;
            da_r <= da_nxt;
            sa_r <= sa_nxt;
            dest_r <= dest_nxt;
            type_r <= type_nxt;
            op_r <= op_nxt;
            quanta_r <= quanta_nxt;
            in_port_r <= in_port_nxt;
            da_port_r <= da_port_nxt;
            err_r <= err_nxt;
            start_buf_r <= start_buf_nxt;
            buf_free_r <= buf_free_nxt;
            alloc_r <= alloc_nxt;
            scan_idx_r <= scan_idx_nxt;
            sa_idx_r <= sa_idx_nxt;
            free_idx_r <= free_idx_nxt;
            sa_hit_r <= sa_hit_nxt;
            da_hit_r <= da_hit_nxt;
            free_hit_r <= free_hit_nxt;
            busy_r <= busy_nxt;
            drop_r <= drop_nxt;
            pause_valid_r <= pause_valid_nxt;
            pause_port_r <= pause_port_nxt;
            pause_quanta_r <= pause_quanta_nxt;
            tx_valid_r <= tx_valid_nxt;
            tx_sof_r <= tx_sof_nxt;
            tx_eof_r <= tx_eof_nxt;
            tx_data_r <= tx_data_nxt;
            tx_map_r <= tx_map_nxt;
            tick_r <= tick_nxt;
            epoch_r <= epoch_nxt;
            age_idx_r <= age_idx_nxt;
            if (tbl_we) begin
                tbl_valid_r[tbl_widx] <= tbl_wvalid;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (pool_we) begin
            pool_r[pool_wa] <= fifo_word[7:0];
        end
        if (tbl_we && tbl_wvalid) begin
            tbl_mac_r[tbl_widx] <= sa_r;
            tbl_port_r[tbl_widx] <= in_port_r;
            tbl_stamp_r[tbl_widx] <= epoch_r;
        end
    end

    assign lookup_busy_o = busy_r;
    assign destination_mac_o = dest_r;
    assign ingress_port_o = in_port_r;
    assign pause_valid_o = pause_valid_r;
    assign pause_port_o = pause_port_r;
    assign pause_quanta_o = pause_quanta_r;
    assign tx_valid_o = tx_valid_r;
    assign tx_sof_o = tx_sof_r;
    assign tx_eof_o = tx_eof_r;
    assign tx_data_o = tx_data_r;
    assign tx_port_map_o = tx_map_r;
    assign drop_o = drop_r;
    assign buffers_free_o = buf_free_r;
endmodule : address_lookup_forwarding

// ---- alf_monitor.sv ----
// Assertion checker for the look-up and forwarding engine.
`timescale 1ns/1ns
module alf_monitor #(
    parameter longint unsigned AGE_TICK_CYCLES = 64
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic lookup_busy_o,
    input wire logic drop_o,
    input wire logic pause_valid_o,
    input wire logic tx_valid_o,
    input wire logic tx_sof_o,
    input wire logic tx_ready_i,
    input wire logic [7:0] tx_data_o,
    input wire logic [4:0] tx_port_map_o,
    input wire logic [2:0] ingress_port_o,
    input wire logic auth_ok_i,
    input wire logic acl_valid_i,
    input wire logic [4:0] acl_map_i,
    input wire logic [9:0] buffers_free_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    a_pause_drops: assert property (pause_valid_o |-> drop_o) else $error("pause not dropped");
    a_pause_pulse: assert property (pause_valid_o |=> !pause_valid_o) else $error("pause pulse long");
    a_busy_no_tx: assert property (lookup_busy_o |-> !tx_valid_o) else $error("egress during lookup");
    a_tx_holds: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o)
        && $stable(tx_port_map_o)) else $error("egress byte changed while stalled");
    a_no_echo: assert property (tx_valid_o && tx_sof_o && !acl_valid_i
        |-> (tx_port_map_o & (5'h01 << ingress_port_o)) == 5'h00) else $error("frame sent to ingress");
    a_auth_drops: assert property (lookup_busy_o && !auth_ok_i ##1 !lookup_busy_o |-> drop_o)
        else $error("unauthenticated frame kept");
    a_acl_wins: assert property (lookup_busy_o && auth_ok_i && acl_valid_i ##1 !lookup_busy_o && !drop_o
        |=> tx_valid_o && tx_port_map_o == acl_map_i) else $error("access-list map not applied");
    a_pool_limit: assert property (buffers_free_o <= 10'h200) else $error("free buffers above pool");
    c_pause: cover property (pause_valid_o);
    c_auth: cover property (!auth_ok_i && drop_o);
    c_acl: cover property (acl_valid_i && tx_valid_o && tx_sof_o);
endmodule : alf_monitor
bind address_lookup_forwarding alf_monitor #(.AGE_TICK_CYCLES(AGE_TICK_CYCLES)) alf_monitor_i (.*);

// ---- mac_sink.sv ----
// Egress MAC model: takes bytes with periodic stalls and measures frames.
`timescale 1ns/1ns
module mac_sink (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic valid_i,
    input wire logic sof_i,
    input wire logic eof_i,
    output logic ready_o,
    output int flen,
    output int done_cnt
);
    int cyc = 0;
    int cnt = 0;
    initial ready_o = 1'h0;
    // Stall one beat in four so the engine must hold its byte
    always @(negedge clock_i) begin
        cyc <= cyc + 1;
        ready_o <= (cyc % 4) != 3;
    end
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt <= 0;
            flen <= 0;
            done_cnt <= 0;
        end else if (valid_i && ready_o) begin
            cnt <= sof_i ? 1 : cnt + 1;
            if (eof_i) begin
                flen <= sof_i ? 1 : cnt + 1;
                done_cnt <= done_cnt + 1;
            end
        end
    end
endmodule : mac_sink

// ---- address_lookup_forwarding_tb_top.sv ----
// Self-checking testbench for the look-up and forwarding engine.
`timescale 1ns/1ns
`include "alf_cfg.svh"
module address_lookup_forwarding_tb_top;
    logic clock_i = 1'h0, reset_n_i = 1'h0, rx_valid_i = 1'h0, rx_sof_i = 1'h0, rx_eof_i = 1'h0, taken = 1'h0;
    logic static_hit_i = 1'h0, igmp_valid_i = 1'h0, auth_ok_i = 1'h1, acl_valid_i = 1'h0, tx_ready_i;
    // Aging held off until its own test so learned entries survive
    logic aging_enable_i = 1'h0;
    logic [7:0] rx_data_i = 8'h00, tx_data_o;
    logic [2:0] rx_port_i = 3'h0, rx_error_i = 3'h0, ingress_port_o, pause_port_o;
    logic [4:0] static_map_i = 5'h00, vlan_member_map_i = 5'h1F, stp_forward_map_i = 5'h1F, igmp_map_i = 5'h00;
    logic [4:0] mirror_map_i = 5'h00, acl_map_i = 5'h00, tx_port_map_o;
    logic rx_ready_o, lookup_busy_o, pause_valid_o, tx_valid_o, tx_sof_o, tx_eof_o, drop_o;
    logic [47:0] destination_mac_o;
    logic [15:0] pause_quanta_o;
    logic [9:0] buffers_free_o;
    int flen, done_cnt, miscompares = 0, n_checks = 0;
    localparam logic [47:0] HD = 48'h080000000000, MA = 48'h02000000000A, MB = 48'h02000000000B;
    localparam logic [47:0] MC = 48'h02000000000C, MD = 48'h02000000000D, ME = 48'h02000000000E;
    localparam logic [47:0] MF = 48'h02000000000F;
    address_lookup_forwarding #(.AGE_TICK_CYCLES(512)) address_lookup_forwarding_i (.*);
    mac_sink mac_sink_i (.clock_i(clock_i), .reset_n_i(reset_n_i), .valid_i(tx_valid_o), .sof_i(tx_sof_o),
        .eof_i(tx_eof_o), .ready_o(tx_ready_i), .flen(flen), .done_cnt(done_cnt));
    always #2 clock_i = ~clock_i;
    always @(posedge clock_i) taken <= rx_valid_i & rx_ready_o;
    task automatic check(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'h1) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : check
    task automatic close_out;
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out
    // Sends one frame and judges drop (exp zero) or egress map and length
    task automatic frame(input logic [2:0] p, input logic [47:0] da, input logic [47:0] sa,
            input logic [47:0] hd, input int len, input logic [2:0] er, input logic [4:0] exp);
        int n;
        n = done_cnt;
        @(negedge clock_i);
        for (int i = 0; i < len; i++) begin
            rx_valid_i = 1'h1;
            rx_sof_i = i == 0;
            rx_eof_i = i == len - 1;
            rx_port_i = p;
            rx_error_i = er;
            rx_data_i = i < 6 ? da[47 - 8 * i -: 8] : i < 12 ? sa[95 - 8 * i -: 8] : i < 18 ? hd[143 - 8 * i -: 8] : 8'hA5;
            do @(negedge clock_i); while (!taken);
        end
        rx_valid_i = 1'h0;
        check(tx_valid_o === 1'h0, "egress before end of frame");
        for (int k = 0; k < 3000 && drop_o !== 1'h1 && tx_valid_o !== 1'h1; k++) @(negedge clock_i);
        check(ingress_port_o === p && destination_mac_o === da, "lookup key");
        if (exp === 5'h00)
            check(drop_o === 1'h1 && tx_valid_o === 1'h0, "frame not dropped");
        else begin
            check(tx_valid_o === 1'h1 && tx_port_map_o === exp, "egress port map");
            check(tx_sof_o === 1'h1 && tx_data_o === da[47:40], "first egress byte");
            for (int k = 0; k < 9000 && done_cnt == n; k++) @(negedge clock_i);
            check(flen == len, "egress length");
        end
    endtask : frame
    task automatic t_learn;
        check(buffers_free_o === 10'h200 && lookup_busy_o === 1'h0, "reset state");
        frame(3'h0, MC, MA, HD, 64, 3'h0, 5'h1E);
        frame(3'h1, MA, MB, HD, 64, 3'h0, 5'h01);
        frame(3'h0, MA, MC, HD, 64, 3'h0, 5'h00);
        frame(3'h2, MB, MA, HD, 65, 3'h0, 5'h02);
        frame(3'h1, MA, MB, HD, 64, 3'h0, 5'h04);
        check(buffers_free_o === 10'h200, "buffers not returned");
        $display("test learn done");
    endtask : t_learn
    task automatic t_errors;
        for (int j = 0; j < 3; j++) frame(3'h3, MA, MD, HD, 64, 3'h1 << j, 5'h00);
        frame(3'h3, MA, MD, HD, 63, 3'h0, 5'h00);
        frame(3'h3, MA, MD, HD, 1537, 3'h0, 5'h00);
        frame(3'h1, MD, MB, HD, 64, 3'h0, 5'h1D);
        $display("test errors done");
    endtask : t_errors
    task automatic t_pause;
        frame(3'h4, `ALF_PAUSE_DA, ME, {`ALF_PAUSE_TYPE, `ALF_PAUSE_OP, 16'h0123}, 64, 3'h0, 5'h00);
        check(pause_valid_o === 1'h1 && pause_port_o === 3'h4 && pause_quanta_o === 16'h0123, "pause");
        $display("test pause done");
    endtask : t_pause
    task automatic t_policy;
        vlan_member_map_i = 5'h0F;
        frame(3'h0, MF, MC, HD, 64, 3'h0, 5'h0E);
        vlan_member_map_i = 5'h1F;
        mirror_map_i = 5'h08;
        frame(3'h0, MB, MC, HD, 64, 3'h0, 5'h0A);
        mirror_map_i = 5'h00;
        acl_valid_i = 1'h1;
        acl_map_i = 5'h11;
        frame(3'h0, MB, MC, HD, 64, 3'h0, 5'h11);
        acl_valid_i = 1'h0;
        auth_ok_i = 1'h0;
        frame(3'h0, MB, MC, HD, 64, 3'h0, 5'h00);
        auth_ok_i = 1'h1;
        // Static answer overrides a local dynamic hit
        static_hit_i = 1'h1;
        static_map_i = 5'h04;
        frame(3'h0, MC, MC, HD, 64, 3'h0, 5'h04);
        static_hit_i = 1'h0;
        igmp_valid_i = 1'h1;
        igmp_map_i = 5'h06;
        frame(3'h0, 48'h01005E000001, MC, HD, 64, 3'h0, 5'h06);
        igmp_valid_i = 1'h0;
        $display("test policy done");
    endtask : t_policy
    task automatic t_aging;
        repeat (4000) @(negedge clock_i);
        frame(3'h0, MB, ME, HD, 64, 3'h0, 5'h02);
        aging_enable_i = 1'h1;
        repeat (5000) @(negedge clock_i);
        frame(3'h0, MB, ME, HD, 64, 3'h0, 5'h1E);
        $display("test aging done");
    endtask : t_aging
    initial begin
        repeat (2) @(negedge clock_i);
        reset_n_i = 1'h1;
        t_learn;
        t_errors;
        t_pause;
        t_policy;
        t_aging;
        close_out;
    end
    // About 33k cycles of traffic and waits; three times that means a hang
    initial begin
        repeat (100000) @(posedge clock_i);
        miscompares++;
        close_out;
    end
endmodule : address_lookup_forwarding_tb_top
